// [core/fbp_flash_dev.sv]
// flash device end: protection decode and command framing
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// [R1] 1M, invert, top clear: half or all
// [R2] 1M, invert, top set: grow from zero
// [R3] 1M, invert, bottom set: start to top
// [R4] 512K plain top set: protect array top
// [R5] 512K plain bottom set: protect array bottom
// [R6] 512K invert: from zero, or all/none
// [R7] 512K invert bottom: start to top
// [R8] drop erase/program touching protected range
// [R9] sectors, 32K and 64K blocks aligned
// [R10] unknown code: standby until next select
// [R11] standby keeps data output released
// [R12] known code: active until select rises
// [R13] sample rising sclk, shift falling; modes 0,3
// [R14] read data follows command, stop anytime
// [R15] write commands must end on byte boundary
// [R16] ignore array access while busy
// [R17] host polls status before commanding; the bench waits on the busy output instead
// [R18] protected region readable, never changed
// [R19] write enable latch gates data changes
// [R20] range decoded combinationally from static variant
// [R21] select rising clears counter and framing
module fbp_flash_dev #(
  parameter logic density = fbp_pkg::fbp_dens_1m,
  parameter int busy_cycles = fbp_pkg::fbp_busy_cycles
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  fbp_link_if.dev link,
  output logic busy,
  output logic write_enable_latch,
  output logic op_pulse,
  output logic [1:0] op_kind,
  output logic [23:0] op_addr,
  output logic [23:0] op_mask,
  output logic op_reject
);
  typedef enum logic [1:0] {fbp_st_idle, fbp_st_cmd, fbp_st_active, fbp_st_standby} fbp_frm_type;
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] si_s;
    logic sclk_q;
    logic cs_q;
    fbp_frm_type frm;
    logic [5:0] bits;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] shout;
    logic so_out;
    logic so_oe;
    logic wr_latch;
    logic [4:0] bp;
    logic prot_inv;
    logic [7:0] sr_new;
    logic [15:0] busy_cnt;
    logic busy;
    logic op_pulse;
    logic [1:0] op_kind;
    logic [23:0] op_addr;
    logic [23:0] op_mask;
    logic op_reject;
  } fbp_dev_type;
  fbp_dev_type st;
  fbp_dev_type next_st;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;
  logic prot_any;
  logic [23:0] top;
  logic [23:0] sz;
  // protected range from protect and invert bits [R20]
  always_comb begin
    logic protect_sel_top;
    logic protect_from_bottom;
    logic [2:0] code;
    protect_sel_top = st.bp[4];
    protect_from_bottom = st.bp[3];
    code = st.bp[2:0];
    top = (density == fbp_pkg::fbp_dens_1m) ? fbp_pkg::fbp_top_1m : fbp_pkg::fbp_top_512k;
    sz = 24'h000000;
    prot_any = 1'b0;
    prot_lo = 24'h000000;
    prot_hi = top;
    case (code)
      3'b001: sz = 24'h001000;
      3'b010: sz = 24'h002000;
      3'b011: sz = 24'h004000;
      3'b100, 3'b101, 3'b110: sz = 24'h008000;
      default: sz = 24'h000000;
    endcase
    if (!protect_sel_top) begin
      if (density == fbp_pkg::fbp_dens_1m) begin
        // halves of the 128KB array [R1]
        if (st.prot_inv) begin
          prot_any = !code[1];
          if (code[0] && !protect_from_bottom) prot_hi = 24'h00ffff;
          if (code[0] && protect_from_bottom) prot_lo = 24'h010000;
        end else begin
          prot_any = code[1] | code[0];
          if (!code[1] && code[0] && !protect_from_bottom) prot_lo = 24'h010000;
          if (!code[1] && code[0] && protect_from_bottom) prot_hi = 24'h00ffff;
        end
      end else begin
        prot_any = st.prot_inv ? !code[0] : code[0]; // [R6]
      end
    end else if (code == 3'b000) begin
      prot_any = st.prot_inv; // all under invert [R2]
    end else if (code == 3'b111) begin
      prot_any = !st.prot_inv; // [R5]
    end else if (st.prot_inv) begin
      prot_any = 1'b1;
      if (protect_from_bottom) prot_lo = sz; // start to top [R3] [R7]
      else prot_hi = top - sz; // grow from zero [R2] [R6]
    end else begin
      prot_any = 1'b1;
      if (protect_from_bottom) prot_hi = sz - 24'h000001; // bottom [R5]
      else prot_lo = top - sz + 24'h000001; // top [R4]
    end
  end
  // framing, command decode and write checks
  always_comb begin
    logic rise;
    logic fall;
    logic cs_hi;
    logic cs_lo;
    logic [23:0] lo;
    logic [23:0] hi;
    logic known;
    logic is_wr;
    next_st = st;
    next_st.sclk_s = {st.sclk_s[1:0], link.sclk};
    next_st.cs_s = {st.cs_s[1:0], link.cs_n};
    next_st.si_s = {st.si_s[1:0], link.si};
    if (st.sclk_s[2] == st.sclk_s[1]) next_st.sclk_q = st.sclk_s[2];
    if (st.cs_s[2] == st.cs_s[1]) next_st.cs_q = st.cs_s[2];
    rise = (st.sclk_s[2] == st.sclk_s[1]) && st.sclk_s[2] && !st.sclk_q; // [R13]
    fall = (st.sclk_s[2] == st.sclk_s[1]) && !st.sclk_s[2] && st.sclk_q; // [R13]
    cs_hi = (st.cs_s[2] == st.cs_s[1]) && st.cs_s[2] && !st.cs_q;
    cs_lo = (st.cs_s[2] == st.cs_s[1]) && !st.cs_s[2] && st.cs_q;
    next_st.op_pulse = 1'b0;
    next_st.op_reject = 1'b0;
    known = 1'b0;
    is_wr = 1'b0;
    lo = 24'h000000;
    hi = 24'h000000;
    if (st.busy) begin
      if (st.busy_cnt == 16'h0000) begin
        next_st.busy = 1'b0;
        if (st.op_kind == 2'd3) begin
          {next_st.prot_inv, next_st.bp} = {st.sr_new[7], st.sr_new[6:2]};
        end
      end else begin
        next_st.busy_cnt = st.busy_cnt - 16'h0001;
      end
    end
    if (cs_lo) begin
      next_st.frm = fbp_st_cmd;
      next_st.bits = 6'd0;
    end else if (cs_hi) begin
      // chip select rising ends the frame [R12] [R21]
      next_st.so_oe = 1'b0;
      if (st.frm == fbp_st_active && !st.busy && st.bits[2:0] == 3'd0) begin // [R15] [R16]
        case (st.cmd)
          fbp_pkg::fbp_cmd_wren: next_st.wr_latch = 1'b1;
          fbp_pkg::fbp_cmd_wrdi: next_st.wr_latch = 1'b0;
          fbp_pkg::fbp_cmd_wrsr, fbp_pkg::fbp_cmd_pp, fbp_pkg::fbp_cmd_se,
          fbp_pkg::fbp_cmd_be32, fbp_pkg::fbp_cmd_be64, fbp_pkg::fbp_cmd_ce,
          fbp_pkg::fbp_cmd_ce2: is_wr = 1'b1; // only data-changing commands [R8]
          default: is_wr = 1'b0; // reads leave the array and latch alone
        endcase
      end
      if (is_wr && st.wr_latch && st.bits >= 6'd8) begin // [R19]
        next_st.op_pulse = 1'b1;
        lo = 24'h000000;
        hi = top;
        next_st.op_kind = 2'd0;
        case (st.cmd)
          fbp_pkg::fbp_cmd_se: begin lo = st.addr & ~fbp_pkg::fbp_sector_mask; // [R9]
            hi = lo | fbp_pkg::fbp_sector_mask; next_st.op_kind = 2'd1; end
          fbp_pkg::fbp_cmd_be32: begin lo = st.addr & ~fbp_pkg::fbp_blk32_mask;
            hi = lo | fbp_pkg::fbp_blk32_mask; next_st.op_kind = 2'd1; end
          fbp_pkg::fbp_cmd_be64: begin lo = st.addr & ~fbp_pkg::fbp_blk64_mask;
            hi = lo | fbp_pkg::fbp_blk64_mask; next_st.op_kind = 2'd1; end
          fbp_pkg::fbp_cmd_pp: begin lo = st.addr; hi = st.addr; next_st.op_kind = 2'd2; end
          fbp_pkg::fbp_cmd_wrsr: next_st.op_kind = 2'd3;
          default: next_st.op_kind = 2'd0; // chip erase
        endcase
        next_st.op_addr = lo;
        next_st.op_mask = hi - lo;
        // any erase or program overlap with the protected range is dropped, status write exempt [R8] [R18]
        if (st.cmd != fbp_pkg::fbp_cmd_wrsr && prot_any && lo <= prot_hi && hi >= prot_lo) begin
          next_st.op_pulse = 1'b0;
          next_st.op_reject = 1'b1;
        end else begin
          next_st.busy = 1'b1;
          next_st.busy_cnt = 16'(busy_cycles - 1);
        end
        next_st.wr_latch = 1'b0;
      end else if (is_wr) begin
        next_st.op_reject = 1'b1;
      end
      next_st.frm = fbp_st_idle;
      next_st.bits = 6'd0;
    end else if (rise && st.frm != fbp_st_idle && st.frm != fbp_st_standby) begin
      if (st.bits != 6'd63) next_st.bits = st.bits + 6'd1;
      if (st.bits < 6'd8) next_st.cmd = {st.cmd[6:0], st.si_s[2]};
      else if (st.bits < 6'd32) next_st.addr = {st.addr[22:0], st.si_s[2]};
      if (st.bits >= 6'd8 && st.bits < 6'd16) next_st.sr_new = {st.sr_new[6:0], st.si_s[2]};
      if (st.bits == 6'd7) begin
        case ({st.cmd[6:0], st.si_s[2]})
          fbp_pkg::fbp_cmd_read, fbp_pkg::fbp_cmd_fread, fbp_pkg::fbp_cmd_rdsr,
          fbp_pkg::fbp_cmd_wren, fbp_pkg::fbp_cmd_wrdi, fbp_pkg::fbp_cmd_wrsr,
          fbp_pkg::fbp_cmd_pp, fbp_pkg::fbp_cmd_se, fbp_pkg::fbp_cmd_be32,
          fbp_pkg::fbp_cmd_be64, fbp_pkg::fbp_cmd_ce, fbp_pkg::fbp_cmd_ce2: known = 1'b1;
          default: known = 1'b0;
        endcase
        next_st.frm = known ? fbp_st_active : fbp_st_standby; // [R10] [R12]
        next_st.shout = {st.prot_inv, st.bp, st.wr_latch, st.busy};
      end
    end else if (fall && st.frm == fbp_st_active && st.bits >= 6'd8) begin
      // status read shifts out after the command [R14]
      if (st.cmd == fbp_pkg::fbp_cmd_rdsr) begin
        next_st.so_oe = 1'b1;
        next_st.so_out = st.shout[7];
        next_st.shout = {st.shout[6:0], st.shout[7]};
      end
    end
    if (next_st.frm == fbp_st_standby) next_st.so_oe = 1'b0; // [R11]
    if (!rst_n) begin
      next_st = '0;
      next_st.cs_s = 3'b111;
      next_st.cs_q = 1'b1;
      next_st.frm = fbp_st_idle;
    end
  end
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end
  assign link.so_out = st.so_out;
  assign link.so_oe = st.so_oe;
  assign busy = st.busy;
  assign write_enable_latch = st.wr_latch;
  assign op_pulse = st.op_pulse;
  assign op_kind = st.op_kind;
  assign op_addr = st.op_addr;
  assign op_mask = st.op_mask;
  assign op_reject = st.op_reject;
endmodule

// [core/fbp_link_if.sv]
// serial link between host controller and flash device
`timescale 1ns/1ps
interface fbp_link_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe;
  logic so;
  assign so = so_oe ? so_out : 1'b1;
  modport host (output sclk, output cs_n, output si, input so);
  modport dev (input sclk, input cs_n, input si, output so_out, output so_oe);
endinterface

// [core/fbp_pkg.sv]
// package for the flash protection and command framing ends
package fbp_pkg;
  // density variants
  localparam logic fbp_dens_1m = 1'b0;
  localparam logic fbp_dens_512k = 1'b1;
  localparam logic [23:0] fbp_top_1m = 24'h01ffff;
  localparam logic [23:0] fbp_top_512k = 24'h00ffff;
  // erase granularities
  localparam logic [23:0] fbp_sector_mask = 24'h000fff;
  localparam logic [23:0] fbp_blk32_mask = 24'h007fff;
  localparam logic [23:0] fbp_blk64_mask = 24'h00ffff;
  // command codes used by the framing logic
  localparam logic [7:0] fbp_cmd_read = 8'h03;
  localparam logic [7:0] fbp_cmd_fread = 8'h0b;
  localparam logic [7:0] fbp_cmd_rdsr = 8'h05;
  localparam logic [7:0] fbp_cmd_wren = 8'h06;
  localparam logic [7:0] fbp_cmd_wrdi = 8'h04;
  localparam logic [7:0] fbp_cmd_wrsr = 8'h01;
  localparam logic [7:0] fbp_cmd_pp = 8'h02;
  localparam logic [7:0] fbp_cmd_se = 8'h20;
  localparam logic [7:0] fbp_cmd_be32 = 8'h52;
  localparam logic [7:0] fbp_cmd_be64 = 8'hd8;
  localparam logic [7:0] fbp_cmd_ce = 8'h60;
  localparam logic [7:0] fbp_cmd_ce2 = 8'hc7;
  // status register fields
  localparam int fbp_st_busy = 0;
  localparam int fbp_st_write_en = 1;
  localparam int fbp_st_bp_lo = 2;
  localparam int fbp_st_invert = 7;
  // busy time of a write operation in system clocks
  localparam int fbp_busy_cycles = 64;
  // host half period of sclk in system clocks (80 ns); must cover the
  // round trip through both three-stage synchronisers plus the output register
  localparam int fbp_half_cycles = 8;
  localparam logic [3:0] fbp_half_cnt = 4'(fbp_half_cycles - 1);
  // host command register offsets (axi4-lite byte addresses)
  localparam logic [3:0] fbp_reg_ctrl = 4'h0;
  localparam logic [3:0] fbp_reg_tx = 4'h4;
  localparam logic [3:0] fbp_reg_rx = 4'h8;
  localparam logic [3:0] fbp_reg_stat = 4'hc;
  localparam int fbp_ctrl_go = 0;
  localparam int fbp_ctrl_cpol = 1;
  localparam int fbp_ctrl_len_lo = 8;
  localparam logic [1:0] fbp_resp_okay = 2'b00;
  localparam logic [1:0] fbp_resp_slverr = 2'b10;
endpackage

// [core/fbp_spi_host.sv]
// host end: axi4-lite controlled spi command engine
`timescale 1ns/1ps
module fbp_spi_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  fbp_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw;
    logic w_got;
    logic [31:0] wd;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpol;
    logic [5:0] len;
    logic [31:0] tx;
    logic [31:0] rx;
    logic run;
    logic [5:0] cnt;
    logic [3:0] div;
    logic sclk;
    logic cs_n;
    logic si;
    logic [2:0] so_s;
  } fbp_host_type;
  fbp_host_type st;
  fbp_host_type next_st;
  always_comb begin
    next_st = st;
    next_st.so_s = {st.so_s[1:0], link.so};
    // write channel: address and data in either order
    if (!st.aw_got && s_axi_awvalid) begin
      next_st.aw_got = 1'b1;
      next_st.aw = s_axi_awaddr;
    end
    if (!st.w_got && s_axi_wvalid) begin
      next_st.w_got = 1'b1;
      next_st.wd = s_axi_wdata;
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = fbp_pkg::fbp_resp_okay;
      if (st.aw == fbp_pkg::fbp_reg_ctrl) begin
        if (!st.run) begin
          // mode and length stay fixed while a frame runs
          next_st.cpol = st.wd[fbp_pkg::fbp_ctrl_cpol]; // mode 0 or 3 [R13]
          next_st.len = st.wd[fbp_pkg::fbp_ctrl_len_lo +: 6];
        end
        if (st.wd[fbp_pkg::fbp_ctrl_go] && !st.run && st.wd[13:8] != 6'd0) begin
          next_st.run = 1'b1;
          next_st.cs_n = 1'b0;
          next_st.cnt = 6'd0;
          next_st.div = fbp_pkg::fbp_half_cnt;
          next_st.si = st.tx[31];
          next_st.sclk = st.wd[fbp_pkg::fbp_ctrl_cpol];
        end
      end else if (st.aw == fbp_pkg::fbp_reg_tx) begin
        if (!st.run) next_st.tx = st.wd;
      end else if (st.aw == fbp_pkg::fbp_reg_rx || st.aw == fbp_pkg::fbp_reg_stat) begin
        next_st.bresp = fbp_pkg::fbp_resp_okay;
      end else begin
        next_st.bresp = fbp_pkg::fbp_resp_slverr;
      end
    end
    // read channel
    if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = fbp_pkg::fbp_resp_okay;
      if (s_axi_araddr == fbp_pkg::fbp_reg_ctrl) begin
        next_st.rdata = {18'h00000, st.len, 6'h00, st.cpol, 1'b0};
      end else if (s_axi_araddr == fbp_pkg::fbp_reg_tx) begin
        next_st.rdata = st.tx;
      end else if (s_axi_araddr == fbp_pkg::fbp_reg_rx) begin
        next_st.rdata = st.rx;
      end else if (s_axi_araddr == fbp_pkg::fbp_reg_stat) begin
        next_st.rdata = {31'h00000000, st.run};
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = fbp_pkg::fbp_resp_slverr;
      end
    end
    // serial engine: drive on falling, sample on rising [R13]
    if (st.run) begin
      if (st.div != 4'd0) begin
        next_st.div = st.div - 4'd1;
      end else begin
        next_st.div = fbp_pkg::fbp_half_cnt;
        if (st.sclk == st.cpol && st.cnt == st.len) begin
          // stop at the idle level after whole bits, count set by software [R14] [R15]
          next_st.run = 1'b0;
          next_st.cs_n = 1'b1;
        end else if (!st.sclk) begin
          // rising edge: device takes si, host takes so [R13]
          next_st.sclk = 1'b1;
          next_st.rx = {st.rx[30:0], st.so_s[2]};
          next_st.cnt = st.cnt + 6'd1;
        end else begin
          // falling edge: next bit out, none before the first rise [R13]
          next_st.sclk = 1'b0;
          if (st.cnt != 6'd0) begin
            next_st.tx = {st.tx[30:0], 1'b0};
            next_st.si = st.tx[30];
          end
        end
      end
    end
    if (!rst_n) begin
      next_st = '0;
      next_st.cs_n = 1'b1;
      next_st.so_s = 3'b111;
    end
  end
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end
  assign link.sclk = st.sclk;
  assign link.cs_n = st.cs_n;
  assign link.si = st.si;
  assign s_axi_awready = !st.aw_got;
  assign s_axi_wready = !st.w_got;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
endmodule

// [verification/fbp_props.sv]
// concurrent checks on the serial link and the device status outputs
`timescale 1ns/1ps
module fbp_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic op_pulse,
  input wire logic op_reject
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // select has been high long enough for the device to see it
  sequence s_frame_closed;
    cs_n && $past(cs_n, 8);
  endsequence
  // a started write operation keeps the device busy for a while
  sequence s_busy_hold;
    busy [*8];
  endsequence
  // data output released between frames
  chk_so_released: assert property (s_frame_closed |-> !so_oe)
    else $error("data output driven outside a frame");
  // accepted operations only after the frame has closed
  chk_op_framed: assert property (op_pulse |-> cs_n && $past(cs_n, 2))
    else $error("operation started inside a frame");
  chk_reject_framed: assert property (op_reject |-> cs_n)
    else $error("refusal flagged inside a frame");
  chk_op_exclusive: assert property (!(op_pulse && op_reject))
    else $error("operation both accepted and refused");
  // accepted write operation needs the latch set during its frame
  chk_op_needs_latch: assert property (op_pulse |-> $past(write_enable_latch, 8))
    else $error("operation accepted without write enable");
  chk_op_busy: assert property (op_pulse |-> ##[0:2] s_busy_hold)
    else $error("operation did not hold busy");
  chk_latch_set_framed: assert property ($rose(write_enable_latch) |-> cs_n)
    else $error("write enable set before the frame closed");
  // host input bit only moves while the serial clock is low
  chk_si_on_low: assert property (!cs_n && $past(!cs_n) && $changed(si) |-> !sclk)
    else $error("serial input changed while clock high");
endmodule

// [verification/flash_block_protect_and_cmd_framing_test.sv]
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ps
module flash_block_protect_and_cmd_framing_test;
  logic clk_sys, rst_n, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, busy, write_enable_latch, op_pulse, op_reject;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rx;
  logic [1:0] bresp, rresp, op_kind, seen_kind;
  logic [23:0] op_addr, op_mask, seen_addr, seen_mask;
  logic op_seen, rej_seen;
  int fails, num_checks;
  fbp_link_if link();
  fbp_flash_dev #(.density(fbp_pkg::fbp_dens_1m)) fbp_flash_dev_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link.dev), .busy(busy),
    .write_enable_latch(write_enable_latch), .op_pulse(op_pulse), .op_kind(op_kind),
    .op_addr(op_addr), .op_mask(op_mask), .op_reject(op_reject));
  fbp_spi_host fbp_spi_host_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(link.host), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fbp_props fbp_props_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n), .si(link.si),
    .so_out(link.so_out), .so_oe(link.so_oe), .busy(busy),
    .write_enable_latch(write_enable_latch), .op_pulse(op_pulse), .op_reject(op_reject));
  // catch the one-cycle operation and refusal pulses
  always @(posedge clk_sys) begin
    if (op_pulse === 1'b1) begin
      op_seen <= 1'b1;
      seen_kind <= op_kind;
      seen_addr <= op_addr;
      seen_mask <= op_mask;
    end
    if (op_reject === 1'b1) begin
      rej_seen <= 1'b1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one register write, address and data offered together
  // bready stays high between writes, so back-to-back calls never toggle it
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  // one framed transfer through the host engine, result left in rx
  task automatic spi(input logic [31:0] tx, input logic [5:0] len, input logic md);
    op_seen <= 1'b0;
    rej_seen <= 1'b0;
    axi_wr(fbp_pkg::fbp_reg_tx, tx);
    axi_wr(fbp_pkg::fbp_reg_ctrl, {18'h0, len, 6'h0, md, 1'b1});
    while (link.cs_n !== 1'b0) @(posedge clk_sys);
    while (link.cs_n !== 1'b1) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    axi_rd(fbp_pkg::fbp_reg_rx, rx);
  endtask
  // wait on the device busy output until it is ready again
  task automatic wait_idle();
    while (busy !== 1'b0) @(posedge clk_sys);
  endtask
  task automatic wren();
    spi({fbp_pkg::fbp_cmd_wren, 24'h0}, 6'd8, 1'b0);
  endtask
  task automatic t_status_modes();
    spi({fbp_pkg::fbp_cmd_rdsr, 24'h0}, 6'd16, 1'b0);
    check(32'(rx[7:0]), 32'h0);
    spi({fbp_pkg::fbp_cmd_rdsr, 24'h0}, 6'd16, 1'b1);
    check(32'(rx[7:0]), 32'h0);
  endtask
  task automatic t_latch();
    spi({fbp_pkg::fbp_cmd_wren, 24'h0}, 6'd9, 1'b0);
    check(32'(write_enable_latch), 32'h0);
    wren();
    spi({fbp_pkg::fbp_cmd_rdsr, 24'h0}, 6'd16, 1'b0);
    check(32'(rx[7:0]), 32'h2);
    spi({fbp_pkg::fbp_cmd_wrdi, 24'h0}, 6'd8, 1'b0);
    check(32'(write_enable_latch), 32'h0);
    spi({fbp_pkg::fbp_cmd_se, 24'h01f000}, 6'd32, 1'b0);
    check(32'(op_seen), 32'h0);
  endtask
  task automatic t_unknown();
    spi({8'hab, 24'h0}, 6'd16, 1'b0);
    check(32'(rx[15:0]), 32'hffff);
    check(32'(op_seen), 32'h0);
  endtask
  // status write that sets invert and protect bits, then read back
  task automatic protect(input logic [7:0] b);
    wren();
    spi({fbp_pkg::fbp_cmd_wrsr, b, 16'h0}, 6'd16, 1'b0);
    check(32'({op_seen, seen_kind}), 32'h7);
    wait_idle();
    spi({fbp_pkg::fbp_cmd_rdsr, 24'h0}, 6'd16, 1'b0);
    check(32'(rx[7:0]), 32'({b[7:2], 2'b00}));
  endtask
  // erase attempt, accepted or refused as expected
  task automatic erase(input logic [7:0] c, input logic [23:0] a, input logic ok,
                       input logic [23:0] m);
    logic chip;
    chip = (c == fbp_pkg::fbp_cmd_ce) || (c == fbp_pkg::fbp_cmd_ce2);
    wren();
    spi({c, a}, chip ? 6'd8 : 6'd32, 1'b0);
    check(32'({op_seen, rej_seen}), 32'({ok, !ok}));
    if (ok) begin
      check(32'(seen_kind), chip ? 32'h0 : 32'h1);
      check(32'(seen_addr), 32'(a));
      check(32'(seen_mask), 32'(m));
    end
    wait_idle();
  endtask
  task automatic t_protect();
    protect(8'hc4);
    erase(fbp_pkg::fbp_cmd_se, 24'h01f000, 1'b1, fbp_pkg::fbp_sector_mask);
    erase(fbp_pkg::fbp_cmd_se, 24'h01e000, 1'b0, 24'h0);
    erase(fbp_pkg::fbp_cmd_be32, 24'h018000, 1'b0, 24'h0);
    erase(fbp_pkg::fbp_cmd_ce, 24'h0, 1'b0, 24'h0);
    protect(8'he4);
    erase(fbp_pkg::fbp_cmd_se, 24'h000000, 1'b1, fbp_pkg::fbp_sector_mask);
    erase(fbp_pkg::fbp_cmd_be64, 24'h000000, 1'b0, 24'h0);
    protect(8'h88);
    erase(fbp_pkg::fbp_cmd_be64, 24'h010000, 1'b1, fbp_pkg::fbp_blk64_mask);
    erase(fbp_pkg::fbp_cmd_be32, 24'h008000, 1'b1, fbp_pkg::fbp_blk32_mask);
    erase(fbp_pkg::fbp_cmd_ce2, 24'h0, 1'b1, fbp_pkg::fbp_top_1m);
    protect(8'h80);
    erase(fbp_pkg::fbp_cmd_se, 24'h010000, 1'b0, 24'h0);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // watchdog sized well above the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    op_seen = 1'b0;
    rej_seen = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_status_modes();
    t_latch();
    t_unknown();
    t_protect();
    test_done();
  end
endmodule
